// ### pport_pkg.sv
// constants and carriers for the pipeline status, host timeout and vector block
// assumes one system clock; the cpu bus is byte wide
package pport_pkg;
  // register offsets on the local cpu bus
  localparam logic [6:0] IVB_ADDR    = 7'h18;
  localparam logic [6:0] HTV_ADDR    = 7'h24;
  localparam logic [6:0] PHS_ADDR    = 7'h34;
  // reset values
  localparam logic [7:0] IVB_RESET   = 8'h00;
  localparam logic [7:0] HTV_RESET   = 8'hFF;
  // timer shape
  localparam int         PRESCALE    = 2048;
  localparam int         TMR_WIDTH   = 14;
  localparam int         CMP_LSB     = 6;
  // negotiation status after a host timeout
  localparam logic [7:0] NEG_TIMEOUT = 8'h22;
  localparam logic [7:0] NEG_CLEAR   = 8'h00;
  // interrupt type codes in the low vector bits
  localparam logic [2:0] IT_NONE     = 3'h0;
  localparam logic [2:0] IT_SM       = 3'h4;
  localparam logic [2:0] IT_PIPE     = 3'h5;
  localparam logic [2:0] IT_BOTH     = 3'h6;
  // vector field split
  localparam int         VEC_LSB     = 3;
  // status bit positions
  localparam int         B_H1_DATA   = 7;
  localparam int         B_H1_TAG    = 6;
  localparam int         B_H2_DATA   = 5;
  localparam int         B_H2_TAG    = 4;
  localparam int         B_XB_DATA   = 3;
  localparam int         B_XB_EMPTY  = 2;
  localparam int         B_XB_PEND   = 1;
  localparam int         B_RL_NZ     = 0;

  // live pipeline state gathered from the data path
  typedef struct packed {
    logic holding_one_has_data;
    logic holding_one_tagged;
    logic holding_two_has_data;
    logic holding_two_tagged;
    logic xfer_buffer_has_data;
    logic xfer_request;           // request active, high true
    logic run_length_count_nonzero;
  } pipe_state_t;

  // timer states, one-hot
  typedef enum logic [2:0] {
    T_IDLE   = 3'b001,
    T_WAIT   = 3'b010,
    T_LOCKED = 3'b100
  } tmr_state_t;
endpackage

// ### pport_status_timer.sv
// pipeline status view, host response timeout timer and interrupt vector
// assumes data path and port state machine share ref_clk_in; the two ack
// pins come from outside and are resynchronised here
//
// What this block does
// - bits 7:6 show holding one data, tag
// - bits 5:4 show holding two data, tag
// - bit 3 buffer has data, bit 2 empty
// - bit 1 set while request waits acknowledge
// - bit 0 set while run-length count nonzero
// - status is read-only live view, resets 0x04
// - timeout value eight bit rw, resets ff
// - fourteen bit counter on clock divided 2048
// - compare value with counter upper eight bits
// - wait step restarts counter, counts until done
// - match before host answer raises timeout interrupt
// - timeout shows negotiation status 0x22
// - after timeout stay locked until lines idle
// - both test bits set suppress all timeouts
// - timer runs from event two awaiting host
// - vector register reads back last written value
// - acknowledge drives base 7:3 and type 2:0
// - low three base bits never reach vector
// - type codes 000,100,101,110 only
`timescale 1ns/100ps
module pport_status_timer #(
  parameter int PRESCALE_DIV = pport_pkg::PRESCALE  // clock divider ahead of counter
) (
  input  wire logic                 ref_clk_in,
  input  wire logic                 rst_in,
  // local cpu register port
  input  wire logic [6:0]           cpu_addr_in,
  input  wire logic                 cpu_rd_in,
  input  wire logic                 cpu_wr_in,
  input  wire logic [7:0]           cpu_wdata_in,
  output logic      [7:0]           host_data_bus_out,
  output logic                      host_data_bus_oe_out,
  // pipeline state and acknowledge pin
  input  wire pport_pkg::pipe_state_t pipe_in,
  input  wire logic                 xfer_ack_n_in,
  // port state machine side
  input  wire logic                 wait_start_in,
  input  wire logic                 host_event_in,
  input  wire logic [1:0]           host_timer_test_in,
  input  wire logic                 lines_idle_in,
  output logic                      timeout_int_out,
  output logic      [7:0]           neg_status_out,
  output logic                      sm_locked_out,
  // service request and acknowledge
  input  wire logic                 sm_req_in,
  input  wire logic                 pipe_req_in,
  input  wire logic                 service_ack_n_in,
  output logic                      service_request_n_out
);
  import pport_pkg::*;

  localparam int PW = $clog2(PRESCALE_DIV);     // prescaler width

  // refuse a divider the counter cannot serve
  if (PRESCALE_DIV < 2 || (1 << PW) != PRESCALE_DIV) begin : g_chk
    $error("PRESCALE_DIV must be a power of two of at least 2");
  end

  // pin synchronisers: three stages per pin
  logic [2:0] ack_sync [2];        // index 0 service ack, 1 transfer ack
  logic [1:0] ack_pin;             // raw pins
  logic [1:0] ack_low;             // settled, active low seen as 1
  assign ack_pin = {xfer_ack_n_in, service_ack_n_in};

  // stage one feeds stage two only; stages two and three must agree
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
        ack_sync[i] <= 3'h7;
        ack_low[i]  <= 1'b0;
      end else begin
        ack_sync[i] <= {ack_sync[i][1:0], ack_pin[i]};
        if (ack_sync[i][1] == ack_sync[i][2]) begin
          ack_low[i] <= ~ack_sync[i][2];
        end
      end
    end
  end

  // registers software writes
  logic [7:0] ivb;                 // interrupt vector base
  logic [7:0] htv;                 // host timeout value

  // decode, if-else per style
  logic sel_ivb, sel_htv, sel_phs;
  assign sel_ivb = (cpu_addr_in == IVB_ADDR);
  assign sel_htv = (cpu_addr_in == HTV_ADDR);
  assign sel_phs = (cpu_addr_in == PHS_ADDR);

  // live status word, never stored
  logic [7:0] phs;
  assign phs[B_H1_DATA]  = pipe_in.holding_one_has_data;
  assign phs[B_H1_TAG]   = pipe_in.holding_one_tagged;
  assign phs[B_H2_DATA]  = pipe_in.holding_two_has_data;
  assign phs[B_H2_TAG]   = pipe_in.holding_two_tagged;
  assign phs[B_XB_DATA]  = pipe_in.xfer_buffer_has_data;
  assign phs[B_XB_EMPTY] = ~pipe_in.xfer_buffer_has_data;
  // pending means requested but acknowledge not yet seen
  assign phs[B_XB_PEND]  = pipe_in.xfer_request & ~ack_low[1];
  assign phs[B_RL_NZ]    = pipe_in.run_length_count_nonzero;

  // read mux; unmapped offsets read zero
  logic [7:0] rd_mux;
  always_comb begin
    if (sel_ivb) begin
      rd_mux = ivb;
    end else if (sel_htv) begin
      rd_mux = htv;
    end else if (sel_phs) begin
      rd_mux = phs;
    end else begin
      rd_mux = 8'h00;
    end
  end

  // writes; the status offset ignores writes
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ivb <= IVB_RESET;
      htv <= HTV_RESET;
    end else if (cpu_wr_in) begin
      if (sel_ivb) begin
        ivb <= cpu_wdata_in;
      end else if (sel_htv) begin
        htv <= cpu_wdata_in;
      end
    end
  end

  // interrupt type from the two request sources
  logic [2:0] it_code;
  assign it_code = (sm_req_in && pipe_req_in) ? IT_BOTH :
                   sm_req_in                  ? IT_SM   :
                   pipe_req_in                ? IT_PIPE : IT_NONE;

  // acknowledge only counts while our request stands
  logic svc_ack;
  assign svc_ack = ack_low[0] & ~service_request_n_out;

  // base low bits are dropped, type fills them
  logic [7:0] vec;
  assign vec = {ivb[7:VEC_LSB], it_code};

  // bus output: vector held during acknowledge, else one-cycle read data
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      host_data_bus_out     <= 8'h00;
      host_data_bus_oe_out  <= 1'b0;
      service_request_n_out <= 1'b1;
    end else begin
      service_request_n_out <= ~(sm_req_in | pipe_req_in);
      if (svc_ack) begin
        host_data_bus_out    <= vec;
        host_data_bus_oe_out <= 1'b1;
      end else begin
        host_data_bus_out    <= cpu_rd_in ? rd_mux : 8'h00;
        host_data_bus_oe_out <= cpu_rd_in;
      end
    end
  end

  // host response timer
  tmr_state_t                 st, next_st;
  logic [PW-1:0]              presc;  // divider
  logic [TMR_WIDTH-1:0]       cnt;    // timeout counter
  logic                       tick;   // divider wrap
  logic                       match;  // upper bits equal value
  logic                       suppress;

  assign tick     = (presc == PW'(PRESCALE_DIV - 1));
  assign match    = (cnt[TMR_WIDTH-1:CMP_LSB] == htv);
  assign suppress = &host_timer_test_in;

  // the answer wins over a same-cycle match, so no false timeout
  logic fire;
  assign fire = (st == T_WAIT) && match && !host_event_in && !suppress;

  // state choice
  always_comb begin
    next_st = st;
    case (st)
      T_IDLE: begin
        if (wait_start_in) begin
          next_st = T_WAIT;
        end
      end
      T_WAIT: begin
        if (fire) begin
          next_st = T_LOCKED;
        end else if (host_event_in) begin
          next_st = T_IDLE;
        end
      end
      T_LOCKED: begin
        if (lines_idle_in) begin
          next_st = T_IDLE;
        end
      end
      default: next_st = T_IDLE;
    endcase
  end

  // counter and divider; a restart clears both so the length is exact
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st    <= T_IDLE;
      presc <= '0;
      cnt   <= '0;
    end else begin
      st <= next_st;
      if (wait_start_in && st != T_LOCKED) begin
        presc <= '0;
        cnt   <= '0;
      end else if (st == T_WAIT) begin
        presc <= presc + PW'(1);
        if (tick) begin
          cnt <= cnt + TMR_WIDTH'(1);
        end
      end
    end
  end

  // status outputs; timeout interrupt is a one-cycle pulse
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      timeout_int_out <= 1'b0;
      neg_status_out  <= NEG_CLEAR;
      sm_locked_out   <= 1'b0;
    end else begin
      timeout_int_out <= fire;
      if (fire) begin
        neg_status_out <= NEG_TIMEOUT;
      end else if (wait_start_in && st != T_LOCKED) begin
        // a refused start while locked leaves the timeout report intact
        neg_status_out <= NEG_CLEAR;
      end
      sm_locked_out <= (next_st == T_LOCKED);
    end
  end

  // checks; a vector cycle overrides a read, so read checks skip it
  // data and empty bits must disagree on the bus itself
  a_status_empty: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    cpu_rd_in && sel_phs && !svc_ack |=> host_data_bus_out[3] != host_data_bus_out[2])
    else $error("buffer data and empty bits agree");
  // expected bits rebuilt from the pipeline inputs, not from phs
  a_status_live: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    cpu_rd_in && sel_phs && !svc_ack |=> host_data_bus_out[7:2] ==
      {$past(pipe_in[6:3]), $past(pipe_in.xfer_buffer_has_data),
       !$past(pipe_in.xfer_buffer_has_data)} && host_data_bus_out[0] ==
      $past(pipe_in.run_length_count_nonzero))
    else $error("status read not live");
  a_htv_reset: assert property (@(posedge ref_clk_in)
    $fell(rst_in) |-> htv == HTV_RESET)
    else $error("timeout value not ff after reset");
  a_fire_match: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    timeout_int_out |-> $past(cnt[TMR_WIDTH-1:CMP_LSB]) == $past(htv))
    else $error("timeout without match");
  a_restart_zero: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    wait_start_in && st == T_IDLE |=> cnt == 0 && presc == 0 && st == T_WAIT)
    else $error("timer did not restart");
  a_status_code: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    timeout_int_out |-> neg_status_out == NEG_TIMEOUT && sm_locked_out)
    else $error("timeout status not 0x22");
  a_locked_hold: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    st == T_LOCKED && !lines_idle_in |=> st == T_LOCKED)
    else $error("lock left early");
  a_test_mute: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $past(suppress) |-> !timeout_int_out)
    else $error("timeout while suppressed");
  a_vector_out: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    svc_ack |=> host_data_bus_oe_out && host_data_bus_out[7:3] == $past(ivb[7:3]))
    else $error("vector base wrong");
  a_type_code: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    svc_ack |=> host_data_bus_out[2:0] inside {3'h0, 3'h4, 3'h5, 3'h6})
    else $error("invalid type code");
  a_tick_count: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    st == T_WAIT && tick && !wait_start_in && !fire && !host_event_in
      |=> cnt == $past(cnt) + 14'h0001)
    else $error("counter missed a tick");
  c_timeout: cover property (@(posedge ref_clk_in) disable iff (rst_in) timeout_int_out);
  c_answer: cover property (@(posedge ref_clk_in) disable iff (rst_in)
    st == T_WAIT ##1 st == T_IDLE);
  c_vector: cover property (@(posedge ref_clk_in) disable iff (rst_in)
    svc_ack && sm_req_in && pipe_req_in);
endmodule

// ### remote_host_model.sv
// stand-in for the remote parallel host and the cpu interrupt acknowledge pin
// assumes the bench shares ref_clk_in and sets the answer delay and ack enable
`timescale 1ns/100ps
module remote_host_model (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic        wait_start_in,
  input  wire logic [15:0] answer_delay_in,
  input  wire logic        ack_enable_in,
  input  wire logic        service_request_n_in,
  output logic             host_event_out,
  output logic             service_ack_n_out
);
  logic [15:0] wait_cnt;  // cycles since the wait step began
  logic        waiting;   // an answer is still owed
  // answer after the set delay; a zero delay means a host that never answers
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || wait_start_in) begin
      wait_cnt       <= 16'h0000;
      waiting        <= wait_start_in;
      host_event_out <= 1'b0;
    end else begin
      wait_cnt       <= wait_cnt + 16'h0001;
      host_event_out <= waiting && (answer_delay_in != 16'h0000)
                        && (wait_cnt == answer_delay_in);
      if (host_event_out) begin
        waiting <= 1'b0;
      end
    end
  end
  // ack only a live request; a released pin sits at its pull-up level
  always_ff @(posedge ref_clk_in) begin
    service_ack_n_out <= rst_in | ~(ack_enable_in & ~service_request_n_in);
  end
endmodule

// ### testbench.sv
// self-checking bench for the status view, host timeout timer and vector
// assumes a short prescaler of 4 so a timeout takes hundreds of cycles
`timescale 1ns/100ps
module testbench;
  import pport_pkg::*;
  localparam int DIV = 4;            // shortened prescaler
  localparam int EXP = 2 * 64 * DIV; // cycles to timeout with value 2
  typedef struct packed {
    pipe_state_t pipe;
    logic        ack_n;
    logic [7:0]  exp;
  } row_t;
  logic        ref_clk_in, rst_in, cpu_rd, cpu_wr, xfer_ack_n, wait_start;
  logic        lines_idle, sm_req, pipe_req, ack_en, host_event, svc_ack_n;
  logic [6:0]  cpu_addr;
  logic [7:0]  cpu_wdata, bus, neg;
  logic [1:0]  tmr_test;
  logic [15:0] delay;
  logic        oe, tmo, locked, svc_req_n;
  pipe_state_t pipe;
  int          failures, n_compared, c1, c2;
  logic [2:0]  codes [4] = '{3'h0, 3'h5, 3'h4, 3'h6};  // by {sm,pipe}
  row_t rows [6] = '{'{7'h40, 1'b1, 8'h84}, '{7'h60, 1'b1, 8'hC4},
                     '{7'h1C, 1'b1, 8'h38}, '{7'h02, 1'b1, 8'h06},
                     '{7'h02, 1'b0, 8'h04}, '{7'h01, 1'b1, 8'h05}};
  pport_status_timer #(.PRESCALE_DIV(DIV)) uut (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .cpu_addr_in(cpu_addr),
    .cpu_rd_in(cpu_rd), .cpu_wr_in(cpu_wr), .cpu_wdata_in(cpu_wdata),
    .host_data_bus_out(bus), .host_data_bus_oe_out(oe), .pipe_in(pipe),
    .xfer_ack_n_in(xfer_ack_n), .wait_start_in(wait_start),
    .host_event_in(host_event), .host_timer_test_in(tmr_test),
    .lines_idle_in(lines_idle), .timeout_int_out(tmo), .neg_status_out(neg),
    .sm_locked_out(locked), .sm_req_in(sm_req), .pipe_req_in(pipe_req),
    .service_ack_n_in(svc_ack_n), .service_request_n_out(svc_req_n));
  remote_host_model host (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .wait_start_in(wait_start),
    .answer_delay_in(delay), .ack_enable_in(ack_en),
    .service_request_n_in(svc_req_n), .host_event_out(host_event),
    .service_ack_n_out(svc_ack_n));
  // free-running 200 MHz clock
  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one write strobe, driven at the falling edge
  task automatic cpu_write(input logic [6:0] a, input logic [7:0] d);
    @(negedge ref_clk_in) {cpu_addr, cpu_wdata, cpu_wr} = {a, d, 1'b1};
    @(negedge ref_clk_in) cpu_wr = 1'b0;
  endtask
  // one read strobe; data and oe land one edge later and stand one cycle
  task automatic cpu_read(input logic [6:0] a, input logic [7:0] exp);
    @(negedge ref_clk_in) {cpu_addr, cpu_rd} = {a, 1'b1};
    @(negedge ref_clk_in) cpu_rd = 1'b0;
    check({oe, bus}, {1'b1, exp}, "register read");
  endtask
  // start a wait step and count cycles until the timeout pulse or the limit
  task automatic run_timer(input int limit, output int cyc);
    @(negedge ref_clk_in) wait_start = 1'b1;
    @(negedge ref_clk_in) wait_start = 1'b0;
    cyc = 0;
    while (tmo !== 1'b1 && cyc < limit) begin
      @(negedge ref_clk_in) cyc++;
    end
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // watchdog well beyond the expected few thousand cycles
  initial begin
    #200000;
    failures++;
    conclude();
  end
  initial begin
    {cpu_rd, cpu_wr, wait_start, lines_idle, sm_req, pipe_req, ack_en} = '0;
    {cpu_addr, cpu_wdata, tmr_test, delay, pipe} = '0;
    xfer_ack_n = 1'b1;
    rst_in = 1'b1;
    repeat (20) @(negedge ref_clk_in);
    rst_in = 1'b0;
    // reset values and the empty-buffer pattern
    cpu_read(IVB_ADDR, 8'h00);
    cpu_read(HTV_ADDR, 8'hFF);
    cpu_read(PHS_ADDR, 8'h04);
    check({svc_req_n, tmo, neg, locked}, {2'b10, 8'h00, 1'b0}, "reset outputs");
    $display("reset values done");
    // live status rows
    foreach (rows[i]) begin
      @(negedge ref_clk_in) {pipe, xfer_ack_n} = {rows[i].pipe, rows[i].ack_n};
      repeat (4) @(negedge ref_clk_in);
      cpu_read(PHS_ADDR, rows[i].exp);
    end
    {pipe, xfer_ack_n} = 8'h01;
    $display("status rows done");
    // register access, read-only and unmapped places
    cpu_write(IVB_ADDR, 8'hAF);
    cpu_write(PHS_ADDR, 8'hFF);
    cpu_write(HTV_ADDR, 8'h02);
    cpu_read(IVB_ADDR, 8'hAF);
    cpu_read(PHS_ADDR, 8'h04);
    cpu_read(HTV_ADDR, 8'h02);
    cpu_read(7'h00, 8'h00);
    $display("register access done");
    // vector cycles for every request mix; low base bits must not leak
    for (int i = 0; i < 4; i++) begin
      @(negedge ref_clk_in) {sm_req, pipe_req} = i[1:0];
      repeat (2) @(negedge ref_clk_in);
      check(svc_req_n, i == 0, "service request");
      ack_en = 1'b1;
      repeat (8) @(negedge ref_clk_in);
      check({oe, bus}, i == 0 ? 9'h000 : {1'b1, 5'h15, codes[i]}, "vector");
      ack_en = 1'b0;
      repeat (8) @(negedge ref_clk_in);
    end
    {sm_req, pipe_req} = 2'b00;
    $display("vector cycles done");
    // silent host with one test bit only: timeout still fires
    tmr_test = 2'b01;
    run_timer(EXP + 50, c1);
    check(c1 >= EXP && c1 <= EXP + 4, 1'b1, "timeout length");
    check({tmo, neg, locked}, {1'b1, NEG_TIMEOUT, 1'b1}, "timeout status");
    run_timer(20, c2);
    check({7'(c2), neg, locked}, {7'd20, NEG_TIMEOUT, 1'b1}, "start while locked");
    lines_idle = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    check(locked, 1'b0, "unlock on idle lines");
    lines_idle = 1'b0;
    repeat (3) @(negedge ref_clk_in);
    tmr_test = 2'b00;
    run_timer(EXP + 50, c2);
    check(16'(c2), 16'(c1), "repeatable timeout length");
    lines_idle = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    lines_idle = 1'b0;
    $display("host timeout done");
    // host answers in time, then both test bits hold the wait forever
    delay = 16'd100;
    run_timer(EXP + 100, c1);
    check({15'(c1), locked}, {15'(EXP + 100), 1'b0}, "answered wait");
    delay = 16'h0000;
    tmr_test = 2'b11;
    run_timer(EXP + 100, c1);
    check({15'(c1), locked}, {15'(EXP + 100), 1'b0}, "suppressed timeout");
    // counter still sits in the matching span, so lifting the bits fires at once
    tmr_test = 2'b00;
    repeat (3) @(negedge ref_clk_in);
    check({7'h00, neg, locked}, {7'h00, NEG_TIMEOUT, 1'b1}, "timeout once unsuppressed");
    $display("answer and suppression done");
    // reset in mid-run, while locked, restores everything
    cpu_write(IVB_ADDR, 8'h5A);
    @(negedge ref_clk_in) rst_in = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    rst_in = 1'b0;
    check({svc_req_n, tmo, neg, locked}, {2'b10, 8'h00, 1'b0}, "outputs after reset");
    cpu_read(IVB_ADDR, 8'h00);
    cpu_read(HTV_ADDR, 8'hFF);
    $display("second reset done");
    conclude();
  end
endmodule
